/* cpu_pc_stack_indirect_core.sv */
// Program counter, return stack, shadow context and indirect pointer sequencing.
`timescale 1ns/100ps
// Behaviour
// - Return stack holds sixteen 15-bit entries.
// - Overflow and underflow set sticky status flags.
// - Stack error causes reset when option enabled.
// - Interrupt entry copies core registers to shadows.
// - Interrupt return restores core registers from shadows.
// - Two 16-bit pointers reach data and program.
// - Program memory indirect access adds one cycle.
// - Linear window maps general RAM across banks.
// - Fifteen-bit program counter over 32K words.
// - Addresses above 0FFFh wrap into implemented space.
// - Reset vector 0000h, interrupt vector 0004h.
// - Pointer high bit 7 selects program memory.
// - Program read returns low eight bits.
// - Indirect writes to program memory are ignored.
module cpu_pc_stack_indirect_core
  import cpu_seq_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              advance_in,
  input  wire logic              jump_in,
  input  wire logic              call_in,
  input  wire logic              return_in,
  input  wire logic              int_take_in,
  input  wire logic              int_return_in,
  input  wire logic [PC_W-1:0]   target_in,
  input  wire logic              stack_reset_en_in,
  input  wire logic              flags_clear_in,
  input  wire logic [SHADOW_W-1:0] status_in,
  input  wire logic [SHADOW_W-1:0] wreg_in,
  input  wire logic [SHADOW_W-1:0] bsr_in,
  input  wire logic [SHADOW_W-1:0] pclath_in,
  input  wire logic              ptr_load_in,
  input  wire logic              ptr_sel_in,
  input  wire logic [PTR_W-1:0]  ptr_value_in,
  input  wire logic              ind_read_in,
  input  wire logic              ind_write_in,
  input  wire logic [DATA_W-1:0] ind_wdata_in,
  input  wire logic [WORD_W-1:0] pmem_rdata_in,
  input  wire logic [DATA_W-1:0] dmem_rdata_in,
  output logic      [PC_W-1:0]   pc_out,
  output logic      [PC_W-1:0]   fetch_addr_out,
  output logic                   stack_overflow_flag_out,
  output logic                   stack_underflow_flag_out,
  output logic                   soft_reset_out,
  output logic                   restore_valid_out,
  output logic      [SHADOW_W-1:0] status_restore_out,
  output logic      [SHADOW_W-1:0] wreg_restore_out,
  output logic      [SHADOW_W-1:0] bsr_restore_out,
  output logic      [SHADOW_W-1:0] pclath_restore_out,
  output logic      [PTR_W-1:0]  ptr0_out,
  output logic      [PTR_W-1:0]  ptr1_out,
  output logic                   stall_out,
  output logic      [PC_W-1:0]   pmem_addr_out,
  output logic                   pmem_rd_out,
  output logic      [15:0]       dmem_addr_out,
  output logic                   dmem_rd_out,
  output logic                   dmem_wr_out,
  output logic      [DATA_W-1:0] dmem_wdata_out,
  output logic      [DATA_W-1:0] ind_rdata_out,
  output logic                   ind_rvalid_out
);
  // ---------------------------------------------------------------
  // Return stack
  // ---------------------------------------------------------------
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] top;
  logic            ovf;
  logic            unf;
  logic            push;
  logic            pop;
  seq_state_t      state_reg;

  assign push = (call_in || int_take_in) && state_reg == SEQ_RUN;
  assign pop  = (return_in || int_return_in) && state_reg == SEQ_RUN;

  pc_return_stack u_stack (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .push_in       (push),
    .pop_in        (pop),
    .push_data_in  (wrap_pc(pc_reg + 15'h0001)),
    .top_out       (top),
    .overflow_out  (ovf),
    .underflow_out (unf),
    .depth_out     ()
  );

  // ---------------------------------------------------------------
  // Program counter
  // ---------------------------------------------------------------
  // A stack error with reset enabled does not hold the counter: the call or return still loads
  // its target, and the reset request one cycle later loads RESET_VECTOR.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_reg <= RESET_VECTOR;
    end else if (soft_reset_out) begin
      pc_reg <= RESET_VECTOR;
    end else if (state_reg == SEQ_RUN) begin
      if (int_take_in) begin
        pc_reg <= INT_VECTOR;
      end else if (return_in || int_return_in) begin
        pc_reg <= wrap_pc(top);
      end else if (call_in || jump_in) begin
        pc_reg <= wrap_pc(target_in);
      end else if (advance_in) begin
        pc_reg <= wrap_pc(pc_reg + 15'h0001);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_out         <= RESET_VECTOR;
      fetch_addr_out <= RESET_VECTOR;
    end else begin
      pc_out         <= pc_reg;
      fetch_addr_out <= wrap_pc(pc_reg);
    end
  end

  // ---------------------------------------------------------------
  // Stack error flags and reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stack_overflow_flag_out  <= 1'b0;
      stack_underflow_flag_out <= 1'b0;
      soft_reset_out           <= 1'b0;
    end else begin
      // Set wins over a simultaneous clear.
      stack_overflow_flag_out  <= ovf || (stack_overflow_flag_out && !flags_clear_in);
      stack_underflow_flag_out <= unf || (stack_underflow_flag_out && !flags_clear_in);
      soft_reset_out           <= (ovf || unf) && stack_reset_en_in;
    end
  end

  // ---------------------------------------------------------------
  // Shadow context
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_restore_out <= '0;
      wreg_restore_out   <= '0;
      bsr_restore_out    <= '0;
      pclath_restore_out <= '0;
    end else if (int_take_in && state_reg == SEQ_RUN) begin
      status_restore_out <= status_in;
      wreg_restore_out   <= wreg_in;
      bsr_restore_out    <= bsr_in;
      pclath_restore_out <= pclath_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      restore_valid_out <= 1'b0;
    end else begin
      restore_valid_out <= int_return_in && state_reg == SEQ_RUN;
    end
  end

  // ---------------------------------------------------------------
  // Indirect pointers and access
  // ---------------------------------------------------------------
  logic [PTR_W-1:0] ptr;
  logic             to_pmem;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr0_out <= '0;
      ptr1_out <= '0;
    end else if (ptr_load_in && !ptr_sel_in) begin
      ptr0_out <= ptr_value_in;
    end else if (ptr_load_in) begin
      ptr1_out <= ptr_value_in;
    end
  end

  assign ptr     = ptr_sel_in ? ptr1_out : ptr0_out;
  assign to_pmem = ptr[PMEM_SEL_BIT];

  // Linear window: each 80-byte GPR slice sits after its bank's SFRs.
  function automatic logic [15:0] map_data(input logic [PTR_W-1:0] p);
    logic [15:0] off;
    logic [15:0] bank;
    off  = p - LINEAR_BASE;
    bank = off / 16'(GPR_BANK_BYTES);
    if (p >= LINEAR_BASE && p <= LINEAR_TOP) begin
      map_data = 16'(bank * 16'(BANK_SIZE)) + 16'(GPR_BASE)
               + (off - 16'(bank * 16'(GPR_BANK_BYTES)));
    end else begin
      map_data = p;
    end
  endfunction : map_data

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= SEQ_RUN;
    end else begin
      unique case (state_reg)
        SEQ_RUN: begin
          if (ind_read_in && to_pmem) state_reg <= SEQ_FETCH;
        end
        SEQ_FETCH: begin
          state_reg <= SEQ_HALT;
        end
        SEQ_HALT: begin
          state_reg <= SEQ_RUN;
        end
        default: state_reg <= SEQ_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stall_out      <= 1'b0;
      pmem_addr_out  <= '0;
      pmem_rd_out    <= 1'b0;
      dmem_addr_out  <= '0;
      dmem_rd_out    <= 1'b0;
      dmem_wr_out    <= 1'b0;
      dmem_wdata_out <= '0;
      ind_rdata_out  <= '0;
      ind_rvalid_out <= 1'b0;
    end else begin
      stall_out      <= state_reg == SEQ_RUN && ind_read_in && to_pmem;
      pmem_rd_out    <= state_reg == SEQ_RUN && ind_read_in && to_pmem;
      pmem_addr_out  <= wrap_pc(ptr[PC_W-1:0]);
      dmem_addr_out  <= map_data(ptr);
      dmem_rd_out    <= state_reg == SEQ_RUN && ind_read_in && !to_pmem;
      dmem_wr_out    <= state_reg == SEQ_RUN && ind_write_in && !to_pmem;
      dmem_wdata_out <= ind_wdata_in;
      ind_rvalid_out <= (state_reg == SEQ_HALT) || dmem_rd_out;
      if (state_reg == SEQ_HALT) begin
        ind_rdata_out <= pmem_rdata_in[DATA_W-1:0];
      end else if (dmem_rd_out) begin
        ind_rdata_out <= dmem_rdata_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_reset_on_error: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ((ovf || unf) && stack_reset_en_in) |=> soft_reset_out ##1 pc_reg == RESET_VECTOR)
    else $error("stack error did not reset");
  chk_ovf_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ovf |=> stack_overflow_flag_out) else $error("overflow flag not set");
  chk_unf_flag_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    unf |=> stack_underflow_flag_out) else $error("underflow flag not set");
  chk_int_vector: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (int_take_in && state_reg == SEQ_RUN && !soft_reset_out) |=> pc_reg == INT_VECTOR)
    else $error("interrupt vector wrong");
  chk_shadow_save: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (int_take_in && state_reg == SEQ_RUN) |=> wreg_restore_out == $past(wreg_in))
    else $error("shadow not captured");
  chk_pc_wrap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    pc_reg <= IMPL_MASK) else $error("pc outside implemented space");
  chk_pmem_extra: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == SEQ_RUN && ind_read_in && to_pmem) |=> stall_out ##2 ind_rvalid_out)
    else $error("program read timing wrong");
  chk_no_pmem_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ind_write_in && to_pmem) |=> !dmem_wr_out) else $error("write to program memory");
  chk_return_pop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (return_in && !int_take_in && state_reg == SEQ_RUN && !soft_reset_out && !unf)
    |=> pc_reg == wrap_pc($past(top))) else $error("return address wrong");

  cov_call: cover property (@(posedge clk_in) push && !pop);
  cov_ovf: cover property (@(posedge clk_in) ovf);
  cov_pmem_read: cover property (@(posedge clk_in) state_reg == SEQ_HALT);
  cov_int_ret: cover property (@(posedge clk_in) restore_valid_out);
endmodule : cpu_pc_stack_indirect_core

/* cpu_seq_pkg.sv */
// Package of constants and types for the program sequencing core.
package cpu_seq_pkg;
  localparam int PC_W           = 15;
  localparam int STACK_DEPTH    = 16;
  localparam int SP_W           = 5;
  localparam int PTR_W          = 16;
  localparam int DATA_W         = 8;
  localparam int WORD_W         = 14;
  localparam int IMPL_ADDR_W    = 12;
  localparam int SHADOW_W       = 8;
  localparam int PMEM_SEL_BIT   = 15;
  localparam int GPR_BANK_BYTES = 80;
  localparam int GPR_BANK_W     = 7;
  localparam int BANK_SIZE      = 128;
  localparam int GPR_BASE       = 32;
  localparam logic [PC_W-1:0]  RESET_VECTOR = 15'h0000;
  localparam logic [PC_W-1:0]  INT_VECTOR   = 15'h0004;
  localparam logic [PC_W-1:0]  IMPL_MASK    = 15'h0FFF;
  localparam logic [SP_W-1:0]  SP_FULL      = 5'h10;
  localparam logic [15:0]      LINEAR_BASE  = 16'h2000;
  localparam logic [15:0]      LINEAR_TOP   = 16'h29AF;

  typedef enum logic [1:0] {
    SEQ_RUN   = 2'b00,
    SEQ_FETCH = 2'b01,
    SEQ_HALT  = 2'b10
  } seq_state_t;

  // Folds any 15-bit program address into the implemented space.
  function automatic logic [PC_W-1:0] wrap_pc(input logic [PC_W-1:0] a);
    wrap_pc = a & IMPL_MASK;
  endfunction : wrap_pc
endpackage : cpu_seq_pkg

/* pc_return_stack.sv */
// Return address stack with overflow and underflow detection.
`timescale 1ns/100ps
module pc_return_stack
  import cpu_seq_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire logic            push_in,
  input  wire logic            pop_in,
  input  wire logic [PC_W-1:0] push_data_in,
  output logic      [PC_W-1:0] top_out,
  output logic                 overflow_out,
  output logic                 underflow_out,
  output logic      [SP_W-1:0] depth_out
);
  logic [PC_W-1:0] mem [STACK_DEPTH];
  logic [SP_W-1:0] depth_reg;

  assign depth_out     = depth_reg;
  assign overflow_out  = push_in && !pop_in && (depth_reg == SP_FULL);
  assign underflow_out = pop_in && !push_in && (depth_reg == '0);
  assign top_out       = (depth_reg == '0) ? RESET_VECTOR
                       : mem[depth_reg[SP_W-2:0] - 4'h1];

  // An overflowing push is dropped so the oldest return addresses survive.
  always_ff @(posedge clk_in) begin
    if (push_in && !pop_in && depth_reg != SP_FULL) begin
      mem[depth_reg[SP_W-2:0]] <= push_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      depth_reg <= '0;
    end else if (push_in && !pop_in && depth_reg != SP_FULL) begin
      depth_reg <= depth_reg + 5'h01;
    end else if (pop_in && !push_in && depth_reg != '0) begin
      depth_reg <= depth_reg - 5'h01;
    end
  end

  chk_stack_bound: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    depth_reg <= SP_FULL) else $error("stack depth beyond sixteen");
endmodule : pc_return_stack

/* mem_array_model.sv */
// Behavioural program and data memory arrays facing the sequencing core.
`timescale 1ns/100ps
module mem_array_model
  import cpu_seq_pkg::*;
(
  input  wire logic [PC_W-1:0]   pmem_addr_in,
  input  wire logic              clk_in,
  input  wire logic              pmem_rd_in,
  input  wire logic [15:0]       dmem_addr_in,
  input  wire logic              dmem_rd_in,
  input  wire logic              dmem_wr_in,
  input  wire logic [DATA_W-1:0] dmem_wdata_in,
  output logic      [WORD_W-1:0] pmem_rdata_out,
  output logic      [DATA_W-1:0] dmem_rdata_out
);
  logic [DATA_W-1:0] dmem [0:4095];
  logic [PC_W-1:0]   paddr_reg;
  logic              pvalid_reg;
  logic [13:0]       noise_reg;
  initial begin
    pvalid_reg = 1'b0;
    noise_reg  = 14'h2D1B;
  end
  // A plain always block, because the initial block above also writes these registers.
  always @(posedge clk_in) begin
    pvalid_reg <= pmem_rd_in;
    paddr_reg  <= pmem_addr_in;
    noise_reg  <= noise_reg + 14'h1B35;
    if (dmem_wr_in) dmem[dmem_addr_in[11:0]] <= dmem_wdata_in;
  end
  // Outside the valid cycle both buses churn, so a late or early sample cannot pass.
  assign pmem_rdata_out = pvalid_reg ? ({paddr_reg[11:0], 2'b01} ^ 14'h1A5C) : noise_reg;
  assign dmem_rdata_out = dmem_rd_in ? dmem[dmem_addr_in[11:0]] : noise_reg[7:0];
endmodule : mem_array_model

/* cpu_pc_stack_indirect_core_tb_top.sv */
// Self-checking bench for the program sequencing core and its memory arrays.
`timescale 1ns/100ps
module cpu_pc_stack_indirect_core_tb_top import cpu_seq_pkg::*;;
  logic clk_in, rst_n_in, stack_reset_en_in, flags_clear_in, ptr_load_in, ptr_sel_in;
  logic ind_read_in, ind_write_in, ovf_m, unf_m;
  logic stack_overflow_flag_out, stack_underflow_flag_out, soft_reset_out, restore_valid_out;
  logic stall_out, pmem_rd_out, dmem_rd_out, dmem_wr_out, ind_rvalid_out;
  logic [5:0]        ctl;
  logic [31:0]       live, seed;
  logic [PC_W-1:0]   target_in, pc_out, fetch_addr_out, pmem_addr_out, pc_m;
  logic [PC_W-1:0]   stk[$];
  logic [7:0]        status_in, wreg_in, bsr_in, pclath_in, ind_wdata_in, dmem_rdata_in;
  logic [7:0]        status_restore_out, wreg_restore_out, bsr_restore_out, pclath_restore_out;
  logic [7:0]        dmem_wdata_out, ind_rdata_out;
  logic [WORD_W-1:0] pmem_rdata_in;
  logic [15:0]       ptr_value_in, ptr0_out, ptr1_out, dmem_addr_out, daddr_seen;
  logic              advance_in, jump_in, call_in, return_in, int_take_in, int_return_in;
  int                errors, tests_run, sr_cnt, rv_cnt, st_cnt, wr_cnt;
  assign {int_return_in, int_take_in, return_in, call_in, jump_in, advance_in} = ctl;
  assign {status_in, wreg_in, bsr_in, pclath_in} = live;
  cpu_pc_stack_indirect_core i_cpu_pc_stack_indirect_core (.*);
  mem_array_model i_mem_array_model (.clk_in(clk_in), .pmem_addr_in(pmem_addr_out),
    .pmem_rd_in(pmem_rd_out), .dmem_addr_in(dmem_addr_out), .dmem_rd_in(dmem_rd_out),
    .dmem_wr_in(dmem_wr_out), .dmem_wdata_in(dmem_wdata_out),
    .pmem_rdata_out(pmem_rdata_in), .dmem_rdata_out(dmem_rdata_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Pulses last one cycle, so they are counted here rather than polled by the tasks.
  always @(posedge clk_in) begin
    if (soft_reset_out === 1'b1) sr_cnt++;
    if (restore_valid_out === 1'b1) rv_cnt++;
    if (stall_out === 1'b1) st_cnt++;
    if (dmem_wr_out === 1'b1) wr_cnt++;
    if (dmem_rd_out === 1'b1) daddr_seen = dmem_addr_out;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [15:0] lin(input logic [15:0] a);
    logic [15:0] o;
    o = a - 16'h2000;
    if (a < 16'h2000 || a > 16'h29AF) return a;
    return (o / 16'h0050) * 16'h0080 + 16'h0020 + (o % 16'h0050);
  endfunction : lin
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  task automatic do_reset();
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    pc_m = RESET_VECTOR;
    stk.delete();
    ovf_m = 1'b0;
    unf_m = 1'b0;
    @(posedge clk_in);
    #1;
    check("pc after reset", pc_out, RESET_VECTOR);
  endtask : do_reset
  // Kinds: 0 advance, 1 jump, 2 call, 3 return, 4 interrupt entry, 5 interrupt return.
  task automatic op(input int k, input logic [PC_W-1:0] t);
    logic err;
    @(posedge clk_in);
    ctl       <= 6'h01 << k;
    target_in <= t;
    @(posedge clk_in);
    ctl <= 6'h00;
    repeat (3) @(posedge clk_in);
    #1;
    err = 1'b0;
    if (k == 2 || k == 4) begin
      if (stk.size() < STACK_DEPTH) stk.push_back((pc_m + 15'h0001) & IMPL_MASK);
      else err = 1'b1;
    end
    if ((k == 3 || k == 5) && stk.size() == 0) err = 1'b1;
    else if (k == 3 || k == 5) pc_m = stk.pop_back();
    ovf_m |= err && (k == 2 || k == 4);
    unf_m |= err && (k == 3 || k == 5);
    case (k)
      0: pc_m = (pc_m + 15'h0001) & IMPL_MASK;
      1, 2: pc_m = t & IMPL_MASK;
      4: pc_m = INT_VECTOR;
      default: if (err) pc_m = RESET_VECTOR;
    endcase
    if (err && stack_reset_en_in) pc_m = RESET_VECTOR;
    check("pc", pc_out, pc_m);
    check("fetch address", fetch_addr_out, pc_m);
    check("overflow flag", stack_overflow_flag_out, ovf_m);
    check("underflow flag", stack_underflow_flag_out, unf_m);
  endtask : op
  task automatic pload(input logic s, input logic [15:0] v);
    @(posedge clk_in);
    ptr_load_in  <= 1'b1;
    ptr_sel_in   <= s;
    ptr_value_in <= v;
    @(posedge clk_in);
    ptr_load_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    check("pointer", s ? ptr1_out : ptr0_out, v);
  endtask : pload
  task automatic wr(input logic [7:0] d);
    @(posedge clk_in);
    ind_write_in <= 1'b1;
    ind_wdata_in <= d;
    @(posedge clk_in);
    ind_write_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask : wr
  task automatic rd(input int lat, output logic [7:0] v);
    int n;
    @(posedge clk_in);
    ind_read_in <= 1'b1;
    for (n = 1; n <= 8; n++) begin
      @(posedge clk_in);
      ind_read_in <= 1'b0;
      #1;
      if (ind_rvalid_out === 1'b1) break;
    end
    check("read latency", n, lat);
    if (n > 8) results();
    v = ind_rdata_out;
    repeat (3) @(posedge clk_in);
  endtask : rd
  initial begin
    logic [31:0] r;
    logic [15:0] a[4];
    logic [7:0]  v;
    int          k, s0;
    {rst_n_in, stack_reset_en_in, flags_clear_in, ptr_load_in, ptr_sel_in} = 5'h00;
    {ind_read_in, ind_write_in, ind_wdata_in, ptr_value_in, ctl, target_in} = '0;
    {errors, tests_run, sr_cnt, rv_cnt, st_cnt, wr_cnt} = '0;
    live = 32'h00000000;
    seed = 32'h25BEC8DE;
    do_reset();
    op(1, 15'h7FFF);
    op(0, 15'h0000);
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      k = int'(r[1:0]);
      if (k == 2 && stk.size() >= 15) k = 3;
      if (k == 3 && stk.size() == 0) k = 2;
      op(k, r[30:16]);
    end
    $display("test random_flow done");
    while (stk.size() < STACK_DEPTH) op(2, 15'(rnd()));
    op(2, 15'(rnd()));
    for (int i = 0; i < 17; i++) op(3, 15'h0000);
    @(posedge clk_in);
    flags_clear_in <= 1'b1;
    @(posedge clk_in);
    flags_clear_in <= 1'b0;
    ovf_m = 1'b0;
    unf_m = 1'b0;
    op(0, 15'h0000);
    $display("test stack_limits done");
    @(posedge clk_in);
    r = rnd();
    live <= r;
    op(4, 15'h0000);
    @(posedge clk_in);
    live <= ~r;
    op(5, 15'h0000);
    check("restore pulses", rv_cnt, 1);
    check("shadows", {status_restore_out, wreg_restore_out, bsr_restore_out,
      pclath_restore_out}, r);
    $display("test interrupt_context done");
    stack_reset_en_in <= 1'b1;
    op(3, 15'h0000);
    check("soft reset pulses", sr_cnt, 1);
    do_reset();
    while (stk.size() < STACK_DEPTH) op(2, 15'(rnd()));
    op(2, 15'(rnd()));
    check("soft reset pulses", sr_cnt, 2);
    stack_reset_en_in <= 1'b0;
    do_reset();
    $display("test stack_error_reset done");
    a = '{16'h2000, 16'h204F, 16'h2050, 16'h29AF};
    for (int i = 0; i < 4; i++) begin
      pload(i[0], a[i]);
      wr(a[i][7:0] ^ 8'hA5);
    end
    for (int i = 0; i < 4; i++) begin
      pload(i[1], a[i]);
      rd(2, v);
      check("data read", v, a[i][7:0] ^ 8'hA5);
      check("linear address", daddr_seen, lin(a[i]));
    end
    $display("test data_pointer done");
    for (int i = 0; i < 2; i++) begin
      a[0] = 16'h8000 | 16'(rnd());
      pload(i[0], a[0]);
      s0 = wr_cnt;
      wr(8'h5A);
      check("program writes", wr_cnt, s0);
      s0 = st_cnt;
      rd(3, v);
      check("stalls", st_cnt, s0 + 1);
      check("program read", v, 8'({a[0][11:0], 2'b01} ^ 14'h1A5C));
    end
    $display("test program_pointer done");
    results();
  end
  initial begin
    repeat (100000) @(posedge clk_in);
    errors++;
    results();
  end
endmodule : cpu_pc_stack_indirect_core_tb_top
